/* File: dmw_bus_target.sv */
/*
 * Behavioural two-wire bus target that records every byte of a frame.
 * Assumes pulled-up lines resolved by the testbench; it acknowledges or refuses.
 */
`timescale 1ns/100ps
module dmw_bus_target (
   // Bus lines.
   input  wire logic scl_i,
   input  wire logic sda_i,
   output logic      sda_oe_o,
   // Test control.
   input  wire logic nack_i
);
   logic [7:0] sh_q;
   logic [7:0] rx [0:15];
   int         nb;
   int         nrx;

   initial begin
      sda_oe_o = 1'b1;
      nb = 0;
      nrx = 0;
   end
   // A falling data line while the clock is high opens a new frame.
   always @(negedge sda_i) begin
      if (scl_i === 1'b1) begin
         nb = 0;
         nrx = 0;
      end
   end
   always @(posedge scl_i) begin
      if (nb < 8) sh_q = {sh_q[6:0], sda_i};
      nb = nb + 1;
      if (nb == 8) begin
         rx[nrx % 16] = sh_q;
         nrx = nrx + 1;
      end
      if (nb == 9) nb = 0;
   end
   // The acknowledge is held low across the ninth clock unless refusal is ordered.
   always @(negedge scl_i) sda_oe_o = !(nb == 8 && !nack_i);
endmodule

/* File: dmw_pkg.sv */
/*
 * Shared constants and types for the data memory write path.
 * Assumes a single 200 MHz core clock; no other file depends on tool settings.
 */
package dmw_pkg;

   // Core clock period and bus timing.
   localparam int unsigned CLK_PERIOD_NS = 5;
   localparam int unsigned BUS_SLOW_HALF_NS = 5000;
   localparam int unsigned BUS_FAST_HALF_NS = 1250;
   localparam int unsigned BUS_SLOW_HALF_CYC = (BUS_SLOW_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BUS_FAST_HALF_CYC = (BUS_FAST_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BUS_CNT_W = 11;

   // Address space limits.
   localparam logic [8:0] PRIMARY_TOP_DEF = 9'h0ff;
   localparam logic [8:0] AUX_TOP = 9'h0ff;

   // Bus framing.
   localparam logic       BUS_DIR_WRITE = 1'b0;
   localparam logic [3:0] BUS_ACK_BIT = 4'h8;
   localparam logic [1:0] HDR_TARGET = 2'h0;
   localparam logic [1:0] HDR_LOC_HIGH = 2'h1;
   localparam logic [1:0] HDR_LOC_LOW = 2'h2;
   localparam logic [1:0] HDR_DONE = 2'h3;

   // Operation requested by the interpreter.
   typedef enum logic [2:0] {
      OP_PRIMARY_STORE,
      OP_AUX_STORE,
      OP_BUS_WRITE_LOC,
      OP_BUS_WRITE_RAW,
      OP_PRELOAD
   } dmw_op_e;

   // Non-volatile area select.
   localparam logic AREA_PRIMARY = 1'b0;
   localparam logic AREA_AUX = 1'b1;

endpackage

/* File: dmw_write_path.sv */
/*
 * Write path from the interpreter into non-volatile data memory, the auxiliary
 * storage area and an external two-wire bus target.
 * Assumes the non-volatile array sits outside on the same clock and pulses
 * nv_done_i when a byte is committed; the bus lines are open drain with pull-ups.
 */
`timescale 1ns/100ps
module dmw_write_path
   import dmw_pkg::*;
#(
   parameter bit         SHARED_MEM   = 1'b0,
   parameter logic [8:0] PRIMARY_TOP  = dmw_pkg::PRIMARY_TOP_DEF,
   parameter int         HALF_SLOW    = dmw_pkg::BUS_SLOW_HALF_CYC,
   parameter int         HALF_FAST    = dmw_pkg::BUS_FAST_HALF_CYC
) (
   // Clock, reset and enable.
   input  wire logic            core_clk_i,
   input  wire logic            rst_i,
   input  wire logic            ce_i,
   // Operation request.
   input  wire logic            cmd_valid_i,
   input  wire dmw_pkg::dmw_op_e cmd_op_i,
   input  wire logic [15:0]     cmd_loc_i,
   output logic                 cmd_ready_o,
   // Data items.
   input  wire logic            item_valid_i,
   input  wire logic [15:0]     item_data_i,
   input  wire logic            item_word_i,
   input  wire logic            item_last_i,
   output logic                 item_ready_o,
   // Program context and bus target setup.
   input  wire logic [8:0]      prog_len_i,
   input  wire logic [6:0]      tgt_addr_i,
   input  wire logic            tgt_fast_i,
   input  wire logic            tgt_word_loc_i,
   // Non-volatile array port.
   output logic                 nv_wr_o,
   output logic                 nv_area_o,
   output logic [7:0]           nv_addr_o,
   output logic [7:0]           nv_data_o,
   input  wire logic            nv_done_i,
   // Two-wire bus pins.
   output logic                 scl_o,
   output logic                 scl_oe_o,
   input  wire logic            sda_i,
   output logic                 sda_o,
   output logic                 sda_oe_o,
   // Status.
   output logic                 busy_o,
   output logic                 range_err_o,
   output logic                 nack_err_o
);
   import dmw_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_HDR, S_ITEM, S_HIGH, S_NVW, S_BUSW, S_STOP} dmw_seq_e;
   typedef enum logic [2:0] {B_IDLE, B_START, B_LO, B_HI, B_STP_LO, B_STP_HI, B_STP_END} dmw_bus_e;

   // Whether a byte may be written at the given address for the operation.
   function automatic logic dmw_ok(input dmw_op_e op, input logic [8:0] plen, input logic [8:0] addr);
      if (op == OP_AUX_STORE) begin
         dmw_ok = (addr <= AUX_TOP);
      end else if (SHARED_MEM && op == OP_PRIMARY_STORE) begin
         // A program that fills the whole space leaves no byte to write.
         dmw_ok = (plen <= PRIMARY_TOP) && (addr <= PRIMARY_TOP - plen);
      end else begin
         dmw_ok = (addr <= PRIMARY_TOP);
      end
   endfunction

   // Sequencer state.
   dmw_seq_e    st_q, st_d;
   dmw_op_e     op_q, op_d;
   logic [8:0]  addr_q, addr_d;
   logic [15:0] loc_q, loc_d;
   logic [1:0]  hdr_q, hdr_d;
   logic [7:0]  hib_q, hib_d;
   logic        hi_q, hi_d, last_q, last_d, first_q, first_d;
   logic        cmd_rdy_q, item_rdy_q;
   logic        nvwr_q, nvwr_d, area_q, area_d;
   logic [7:0]  nvaddr_q, nvaddr_d, nvdata_q, nvdata_d;
   logic        bgo_q, bgo_d, bstop_q, bstop_d, bfirst_q, bfirst_d;
   logic [7:0]  bbyte_q, bbyte_d;
   logic        rerr_q, rerr_d, nerr_q, nerr_d;
   logic        emit_v, adv_v, is_bus;
   logic [7:0]  emit_b;
   logic        busy_d;

   // Bus engine state.
   dmw_bus_e               bst_q, bst_d;
   logic [BUS_CNT_W-1:0]   cnt_q, cnt_d;
   logic [3:0]             bit_q, bit_d;
   logic [7:0]             sh_q, sh_d;
   logic                   scl_lo_q, scl_lo_d, sda_lo_q, sda_lo_d;
   logic                   bdone_q, bdone_d, bnack_q, bnack_d;
   logic                   sda_m_q, sda_s_q;
   logic [BUS_CNT_W-1:0]   half_v, mid_v;

   assign is_bus = (op_q == OP_BUS_WRITE_LOC) || (op_q == OP_BUS_WRITE_RAW);

   always_comb begin
      st_d = st_q; op_d = op_q; addr_d = addr_q; loc_d = loc_q; hdr_d = hdr_q;
      hib_d = hib_q; hi_d = hi_q; last_d = last_q; first_d = first_q;
      nvwr_d = 1'b0; area_d = area_q; nvaddr_d = nvaddr_q; nvdata_d = nvdata_q;
      bgo_d = 1'b0; bstop_d = 1'b0; bfirst_d = bfirst_q; bbyte_d = bbyte_q;
      rerr_d = rerr_q; nerr_d = nerr_q;
      emit_v = 1'b0; emit_b = 8'h00; adv_v = 1'b0;
      case (st_q)
         S_IDLE: begin
            if (cmd_valid_i && cmd_rdy_q) begin
               op_d = cmd_op_i;
               addr_d = {1'b0, cmd_loc_i[7:0]};
               loc_d = cmd_loc_i;
               rerr_d = 1'b0;
               nerr_d = 1'b0;
               first_d = 1'b1;
               if (cmd_op_i == OP_BUS_WRITE_LOC || cmd_op_i == OP_BUS_WRITE_RAW) begin
                  hdr_d = HDR_TARGET;
                  st_d = S_HDR;
               end else begin
                  hdr_d = HDR_DONE;
                  st_d = S_ITEM;
               end
            end
         end
         S_HDR: begin
            emit_v = 1'b1;
            if (hdr_q == HDR_TARGET) begin
               emit_b = {tgt_addr_i, BUS_DIR_WRITE};
            end else if (hdr_q == HDR_LOC_HIGH) begin
               emit_b = loc_q[15:8];
            end else begin
               emit_b = loc_q[7:0];
            end
         end
         S_ITEM: begin
            if (item_valid_i && item_rdy_q) begin
               hib_d = item_data_i[15:8];
               hi_d = item_word_i;
               last_d = item_last_i;
               emit_v = 1'b1;
               emit_b = item_data_i[7:0];
            end
         end
         S_HIGH: begin
            hi_d = 1'b0;
            emit_v = 1'b1;
            emit_b = hib_q;
         end
         S_NVW: begin
            if (nv_done_i) begin
               addr_d = addr_q + 9'h001;
               adv_v = 1'b1;
            end
         end
         S_BUSW: begin
            if (bdone_q) begin
               nerr_d = nerr_q | bnack_q;
               adv_v = 1'b1;
            end
         end
         S_STOP: begin
            if (bdone_q) begin
               st_d = S_IDLE;
            end
         end
         default: begin
            st_d = S_IDLE;
         end
      endcase
      if (emit_v) begin
         if (is_bus) begin
            bgo_d = 1'b1;
            bbyte_d = emit_b;
            bfirst_d = first_q;
            first_d = 1'b0;
            st_d = S_BUSW;
         end else if (dmw_ok(op_q, prog_len_i, addr_q)) begin
            nvwr_d = 1'b1;
            // The area moves only with a strobe; a preload never selects the auxiliary area.
            area_d = (op_q == OP_AUX_STORE) ? AREA_AUX : AREA_PRIMARY;
            nvaddr_d = addr_q[7:0];
            nvdata_d = emit_b;
            st_d = S_NVW;
         end else begin
            rerr_d = 1'b1;
            addr_d = addr_q + 9'h001;
            adv_v = 1'b1;
         end
      end
      if (adv_v) begin
         if (hdr_q != HDR_DONE) begin
            if (hdr_q == HDR_TARGET && op_q == OP_BUS_WRITE_RAW) begin
               hdr_d = HDR_DONE;
            end else if (hdr_q == HDR_TARGET) begin
               hdr_d = tgt_word_loc_i ? HDR_LOC_HIGH : HDR_LOC_LOW;
            end else if (hdr_q == HDR_LOC_HIGH) begin
               hdr_d = HDR_LOC_LOW;
            end else begin
               hdr_d = HDR_DONE;
            end
            st_d = (hdr_d == HDR_DONE) ? S_ITEM : S_HDR;
         end else if (hi_d) begin
            st_d = S_HIGH;
         end else if (last_d) begin
            bstop_d = is_bus;
            st_d = is_bus ? S_STOP : S_IDLE;
         end else begin
            st_d = S_ITEM;
         end
      end
      busy_d = (st_d != S_IDLE);
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_q <= S_IDLE; op_q <= OP_PRIMARY_STORE; addr_q <= '0; loc_q <= '0; hdr_q <= HDR_DONE;
         hib_q <= '0; hi_q <= 1'b0; last_q <= 1'b0; first_q <= 1'b0;
         cmd_rdy_q <= 1'b0; item_rdy_q <= 1'b0;
         nvwr_q <= 1'b0; area_q <= AREA_PRIMARY; nvaddr_q <= '0; nvdata_q <= '0;
         bgo_q <= 1'b0; bstop_q <= 1'b0; bfirst_q <= 1'b0; bbyte_q <= '0;
         rerr_q <= 1'b0; nerr_q <= 1'b0; busy_o <= 1'b0;
      end else if (ce_i) begin
         st_q <= st_d; op_q <= op_d; addr_q <= addr_d; loc_q <= loc_d; hdr_q <= hdr_d;
         hib_q <= hib_d; hi_q <= hi_d; last_q <= last_d; first_q <= first_d;
         cmd_rdy_q <= (st_d == S_IDLE);
         // Ready drops for a cycle after every take, even when the byte is skipped.
         item_rdy_q <= (st_d == S_ITEM) && !(item_valid_i && item_rdy_q);
         nvwr_q <= nvwr_d; area_q <= area_d; nvaddr_q <= nvaddr_d; nvdata_q <= nvdata_d;
         bgo_q <= bgo_d; bstop_q <= bstop_d; bfirst_q <= bfirst_d; bbyte_q <= bbyte_d;
         rerr_q <= rerr_d; nerr_q <= nerr_d; busy_o <= busy_d;
      end
   end

   // Bus bit engine: SCL is held low between bytes of one frame.
   always_comb begin
      bst_d = bst_q; cnt_d = cnt_q; bit_d = bit_q; sh_d = sh_q;
      scl_lo_d = scl_lo_q; sda_lo_d = sda_lo_q; bdone_d = 1'b0; bnack_d = bnack_q;
      half_v = tgt_fast_i ? BUS_CNT_W'(HALF_FAST) : BUS_CNT_W'(HALF_SLOW);
      mid_v = half_v >> 1;
      if (bst_q != B_IDLE && cnt_q != '0) begin
         cnt_d = cnt_q - BUS_CNT_W'(1);
      end
      case (bst_q)
         B_IDLE: begin
            if (bgo_q) begin
               sh_d = bbyte_q;
               bit_d = '0;
               cnt_d = half_v;
               if (bfirst_q) begin
                  sda_lo_d = 1'b1;
                  bst_d = B_START;
               end else begin
                  bst_d = B_LO;
               end
            end else if (bstop_q) begin
               cnt_d = half_v;
               bst_d = B_STP_LO;
            end
         end
         B_START: begin
            if (cnt_q == '0) begin
               scl_lo_d = 1'b1;
               cnt_d = half_v;
               bst_d = B_LO;
            end
         end
         B_LO: begin
            if (cnt_q == mid_v) begin
               sda_lo_d = (bit_q == BUS_ACK_BIT) ? 1'b0 : ~sh_q[7];
            end
            if (cnt_q == '0) begin
               scl_lo_d = 1'b0;
               cnt_d = half_v;
               bst_d = B_HI;
            end
         end
         B_HI: begin
            if (cnt_q == '0) begin
               scl_lo_d = 1'b1;
               cnt_d = half_v;
               if (bit_q == BUS_ACK_BIT) begin
                  bnack_d = sda_s_q;
                  bdone_d = 1'b1;
                  bst_d = B_IDLE;
               end else begin
                  sh_d = {sh_q[6:0], 1'b0};
                  bit_d = bit_q + 4'h1;
                  bst_d = B_LO;
               end
            end
         end
         B_STP_LO: begin
            if (cnt_q == mid_v) begin
               sda_lo_d = 1'b1;
            end
            if (cnt_q == '0) begin
               scl_lo_d = 1'b0;
               cnt_d = half_v;
               bst_d = B_STP_HI;
            end
         end
         B_STP_HI: begin
            if (cnt_q == '0) begin
               sda_lo_d = 1'b0;
               cnt_d = half_v;
               bst_d = B_STP_END;
            end
         end
         B_STP_END: begin
            if (cnt_q == '0) begin
               bdone_d = 1'b1;
               bst_d = B_IDLE;
            end
         end
         default: begin
            bst_d = B_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         bst_q <= B_IDLE; cnt_q <= '0; bit_q <= '0; sh_q <= '0;
         scl_lo_q <= 1'b0; sda_lo_q <= 1'b0; bdone_q <= 1'b0; bnack_q <= 1'b0;
         sda_m_q <= 1'b1; sda_s_q <= 1'b1;
      end else if (ce_i) begin
         bst_q <= bst_d; cnt_q <= cnt_d; bit_q <= bit_d; sh_q <= sh_d;
         scl_lo_q <= scl_lo_d; sda_lo_q <= sda_lo_d; bdone_q <= bdone_d; bnack_q <= bnack_d;
         sda_m_q <= sda_i;
         sda_s_q <= sda_m_q;
      end
   end

   // Open-drain pins: the enable is low exactly while the line is pulled down.
   assign scl_o = 1'b0;
   assign sda_o = 1'b0;
   assign scl_oe_o = ~scl_lo_q;
   assign sda_oe_o = ~sda_lo_q;
   assign cmd_ready_o = cmd_rdy_q;
   assign item_ready_o = item_rdy_q;
   assign nv_wr_o = nvwr_q;
   assign nv_area_o = area_q;
   assign nv_addr_o = nvaddr_q;
   assign nv_data_o = nvdata_q;
   assign range_err_o = rerr_q;
   assign nack_err_o = nerr_q;

endmodule

/* File: dmw_write_path_props.sv */
/*
 * Port-level checks on the data memory write path.
 * Assumes one clock domain and ce_i held high while the checks run.
 */
`timescale 1ns/100ps
module dmw_write_path_props (
   // Clock, reset and enable.
   input wire logic       core_clk_i,
   input wire logic       rst_i,
   input wire logic       ce_i,
   // Request handshakes.
   input wire logic       cmd_valid_i,
   input wire logic       cmd_ready_o,
   input wire logic       item_valid_i,
   input wire logic       item_ready_o,
   // Non-volatile port.
   input wire logic       nv_wr_o,
   input wire logic       nv_area_o,
   input wire logic [7:0] nv_addr_o,
   input wire logic [7:0] nv_data_o,
   input wire logic       nv_done_i,
   // Status and bus enables.
   input wire logic       busy_o,
   input wire logic       scl_oe_o,
   input wire logic       sda_oe_o
);
   logic pend_q;
   logic pend_d;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);

   // Tracks a byte handed to the array that has not been committed yet.
   always_comb begin
      pend_d = pend_q;
      if (nv_wr_o) pend_d = 1'b1;
      else if (nv_done_i) pend_d = 1'b0;
   end
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) pend_q <= 1'b0;
      else pend_q <= pend_d;
   end

   property p_take; cmd_valid_i && cmd_ready_o && ce_i |=> !cmd_ready_o && busy_o; endproperty
   a_take:
      assert property (p_take) else $error("operation not taken cleanly");
   property p_item; item_valid_i && item_ready_o && ce_i |=> !item_ready_o; endproperty
   a_item:
      assert property (p_item) else $error("item ready stayed high after taking");
   property p_strobe; nv_wr_o |=> !nv_wr_o; endproperty
   a_strobe:
      assert property (p_strobe) else $error("write strobe longer than one cycle");
   property p_pend; nv_wr_o |-> !pend_q; endproperty
   a_pend:
      assert property (p_pend) else $error("new byte before previous one committed");
   property p_idle_nv; cmd_ready_o |-> !nv_wr_o && !item_ready_o; endproperty
   a_idle_nv:
      assert property (p_idle_nv) else $error("memory activity while idle");
   property p_idle_bus; cmd_ready_o |-> scl_oe_o && sda_oe_o; endproperty
   a_idle_bus:
      assert property (p_idle_bus) else $error("bus held while idle");
   property p_stable; !nv_wr_o |-> $stable(nv_addr_o) && $stable(nv_data_o) && $stable(nv_area_o); endproperty
   a_stable:
      assert property (p_stable) else $error("array address or data moved without strobe");
   property p_nv_bus; nv_wr_o |-> scl_oe_o && sda_oe_o; endproperty
   a_nv_bus:
      assert property (p_nv_bus) else $error("bus driven during a memory store");
endmodule

bind dmw_write_path dmw_write_path_props u_props (
   .core_clk_i  (core_clk_i),
   .rst_i       (rst_i),
   .ce_i        (ce_i),
   .cmd_valid_i (cmd_valid_i),
   .cmd_ready_o (cmd_ready_o),
   .item_valid_i(item_valid_i),
   .item_ready_o(item_ready_o),
   .nv_wr_o     (nv_wr_o),
   .nv_area_o   (nv_area_o),
   .nv_addr_o   (nv_addr_o),
   .nv_data_o   (nv_data_o),
   .nv_done_i   (nv_done_i),
   .busy_o      (busy_o),
   .scl_oe_o    (scl_oe_o),
   .sda_oe_o    (sda_oe_o)
);

/* File: dmw_write_path_tb.sv */
/*
 * Self-checking testbench for the data memory write path.
 * Assumes the array model here and the bus target model beside the design.
 */
`timescale 1ns/100ps
module dmw_write_path_tb;
   import dmw_pkg::*;
   logic        core_clk_i, rst_i, cmd_valid_i, item_valid_i, item_word_i, item_last_i;
   logic        nv_done_i, tgt_fast_i, tgt_word_loc_i, nack, tgt_oe;
   logic        cmd_ready_o, item_ready_o, nv_wr_o, nv_area_o, scl_o, scl_oe_o, sda_o, sda_oe_o;
   logic        busy_o, range_err_o, nack_err_o;
   dmw_op_e     cmd_op_i;
   logic [15:0] cmd_loc_i, item_data_i, loc;
   logic [6:0]  tgt_addr_i;
   logic [8:0]  plen;
   int          lim;
   logic [7:0]  nv_addr_o, nv_data_o, a0, a1;
   logic [7:0]  prim [0:255];
   logic [7:0]  aux [0:255];
   logic [7:0]  eq [$];
   logic [7:0]  bq [$];
   logic [15:0] it_d [0:3];
   logic        it_w [0:3];
   int          seed = 10;
   int          failures = 0;
   int          n_checks = 0;
   wire         sda_w = (sda_oe_o ? 1'b1 : sda_o) & tgt_oe;
   wire         scl_w = scl_oe_o ? 1'b1 : scl_o;

   dmw_write_path #(.SHARED_MEM(1'b1), .HALF_SLOW(8), .HALF_FAST(4)) u_dut (
      .core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_loc_i(cmd_loc_i), .cmd_ready_o(cmd_ready_o),
      .item_valid_i(item_valid_i), .item_data_i(item_data_i), .item_word_i(item_word_i),
      .item_last_i(item_last_i), .item_ready_o(item_ready_o),
      .prog_len_i(plen), .tgt_addr_i(tgt_addr_i), .tgt_fast_i(tgt_fast_i), .tgt_word_loc_i(tgt_word_loc_i),
      .nv_wr_o(nv_wr_o), .nv_area_o(nv_area_o), .nv_addr_o(nv_addr_o), .nv_data_o(nv_data_o),
      .nv_done_i(nv_done_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_o(sda_oe_o), .busy_o(busy_o), .range_err_o(range_err_o), .nack_err_o(nack_err_o));
   dmw_bus_target u_tgt (.scl_i(scl_w), .sda_i(sda_w), .sda_oe_o(tgt_oe), .nack_i(nack));

   initial begin
      core_clk_i = 1'b0;
      forever #2.5 core_clk_i = ~core_clk_i;
   end

   // Array model: commits each strobed byte after a random latency.
   initial begin
      nv_done_i = 1'b0;
      forever begin
         @(posedge core_clk_i);
         if (nv_wr_o === 1'b1) begin
            repeat ($random(seed) & 3) @(posedge core_clk_i);
            #1 nv_done_i = 1'b1;
            if (nv_area_o) aux[nv_addr_o] = nv_data_o;
            else prim[nv_addr_o] = nv_data_o;
            @(posedge core_clk_i);
            #1 nv_done_i = 1'b0;
         end
      end
   end

   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task test_done;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task fill(input int n);
      for (int i = 0; i < n; i++) begin
         it_d[i] = 16'($random(seed));
         it_w[i] = 1'($random(seed));
      end
   endtask

   // Issues one operation with n items and waits for its end; expected bytes land in eq.
   task run_op(input dmw_op_e op, input logic [15:0] at, input int n);
      int k;
      cmd_op_i = op;
      cmd_loc_i = at;
      cmd_valid_i = 1'b1;
      k = 0;
      do begin @(posedge core_clk_i); k++; end while (cmd_ready_o !== 1'b1 && k < 5000);
      if (cmd_ready_o !== 1'b1) failures++;
      #1 cmd_valid_i = 1'b0;
      eq.delete();
      for (int i = 0; i < n; i++) begin
         item_data_i = it_d[i];
         item_word_i = it_w[i];
         item_last_i = (i == n - 1);
         item_valid_i = 1'b1;
         k = 0;
         do begin @(posedge core_clk_i); k++; end while (item_ready_o !== 1'b1 && k < 20000);
         if (item_ready_o !== 1'b1) failures++;
         // Valid stays up between items; only the last take releases it.
         #1 if (i == n - 1) item_valid_i = 1'b0;
         eq.push_back(it_d[i][7:0]);
         if (it_w[i]) eq.push_back(it_d[i][15:8]);
      end
      k = 0;
      do begin @(posedge core_clk_i); k++; end while (cmd_ready_o !== 1'b1 && k < 20000);
      if (cmd_ready_o !== 1'b1) failures++;
      #1 chk(busy_o, 16'h0000);
   endtask

   task chk_mem(input bit ar, input logic [15:0] at, input int lim);
      logic [8:0] a;
      foreach (eq[k]) begin
         a = {1'b0, at[7:0]} + 9'(k);
         if (int'(a) <= lim) chk(ar ? aux[a[7:0]] : prim[a[7:0]], eq[k]);
      end
   endtask

   initial begin
      rst_i = 1'b1;
      cmd_valid_i = 1'b0;
      item_valid_i = 1'b0;
      item_word_i = 1'b0;
      item_last_i = 1'b0;
      cmd_op_i = OP_PRIMARY_STORE;
      cmd_loc_i = 16'h0000;
      item_data_i = 16'h0000;
      tgt_addr_i = 7'h50;
      tgt_fast_i = 1'b0;
      tgt_word_loc_i = 1'b0;
      nack = 1'b0;
      plen = 9'h000;
      repeat (20) @(posedge core_clk_i);
      #1 rst_i = 1'b0;
      // Primary stores mixing bytes and words; the first runs past the top address.
      // From the fourth on, they shrink the writable space by a program length, the last one to nothing.
      for (int r = 0; r < 6; r++) begin
         loc = (r == 0) ? 16'h00fe : 16'($random(seed)) & 16'h00ff;
         plen = (r < 3) ? 9'h000 : (r == 5) ? 9'h140 : 9'($random(seed)) & 9'h0ff;
         lim = (plen > PRIMARY_TOP_DEF) ? -1 : int'(PRIMARY_TOP_DEF) - int'(plen);
         fill(3);
         it_w[1] = 1'b1;
         run_op(OP_PRIMARY_STORE, loc, 3);
         chk_mem(1'b0, loc, lim);
         chk(range_err_o, 16'(int'(loc) + eq.size() - 1 > lim));
      end
      // Auxiliary bytes, then a program load that must leave them alone.
      loc = 16'($random(seed)) & 16'h007f;
      fill(2);
      it_w[0] = 1'b0;
      it_w[1] = 1'b0;
      run_op(OP_AUX_STORE, loc, 2);
      chk_mem(1'b1, loc, int'(AUX_TOP));
      a0 = eq[0];
      a1 = eq[1];
      fill(2);
      run_op(OP_PRELOAD, loc, 2);
      chk_mem(1'b0, loc, int'(PRIMARY_TOP_DEF));
      chk(aux[loc[7:0]], a0);
      chk(aux[loc[7:0] + 8'h01], a1);
      // Bus writes: two-byte location, one-byte location, no location, refused bytes.
      for (int r = 0; r < 4; r++) begin
         tgt_addr_i = 7'($random(seed));
         tgt_fast_i = r[0];
         tgt_word_loc_i = (r == 0);
         nack = (r == 3);
         loc = 16'($random(seed));
         fill(2);
         run_op((r == 2) ? OP_BUS_WRITE_RAW : OP_BUS_WRITE_LOC, loc, 2);
         bq.delete();
         bq.push_back({tgt_addr_i, BUS_DIR_WRITE});
         if (r == 0) bq.push_back(loc[15:8]);
         if (r != 2) bq.push_back(loc[7:0]);
         bq = {bq, eq};
         chk(16'(u_tgt.nrx), 16'(bq.size()));
         foreach (bq[i]) chk(u_tgt.rx[i], bq[i]);
         chk(nack_err_o, 16'(r == 3));
      end
      test_done;
   end

   // Cuts a hang short well beyond the expected run length.
   initial begin
      repeat (50000) @(posedge core_clk_i);
      failures++;
      test_done;
   end
endmodule
